// ### rtl/itm_input_mapper.sv
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps

module itm_input_mapper (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // terminal pins
  input wire logic [itm_pkg::NUM_TERM-1:0] term_in,
  // register port
  input wire itm_pkg::itm_bus_req_s bus_req,
  output logic [itm_pkg::DATA_W-1:0] rd_data_q,
  // drive commands
  output itm_pkg::itm_cmd_s cmd_q,
  output logic trip_latched_q,
  output logic [itm_pkg::DATA_W-1:0] external_trip_code_q,
  // interrupt
  output logic irq_q
);

  // synchronised and polarity-adjusted terminal levels
  logic [itm_pkg::NUM_TERM-1:0] term_sync;
  logic [itm_pkg::NUM_TERM-1:0] term_level;

  // per-terminal configuration
  logic [itm_pkg::FUNC_W-1:0] func_q [itm_pkg::NUM_TERM];
  logic [itm_pkg::NUM_TERM-1:0] act_q;

  // option one-hots, one per terminal, then merged
  logic [itm_pkg::NUM_OPT-1:0] term_hot [itm_pkg::NUM_TERM];
  logic [itm_pkg::NUM_OPT-1:0] opt_act;

  // register port decode
  logic [itm_pkg::GRP_W-1:0] wr_grp;
  logic [itm_pkg::IDX_W-1:0] wr_idx;
  logic cfg_idx_ok;
  logic status_wr;
  logic mask_wr;

  // trip edge detection and run gating
  logic ext_prev_q;
  logic ext_rise;
  logic reset_active;
  logic run_ok;

  // drive command path
  itm_pkg::itm_cmd_s cmd_d;

  // trip history
  logic [itm_pkg::DATA_W-1:0] trip_cnt_q;

  // sticky events, mask and read path
  logic [itm_pkg::STAT_W-1:0] status_q;
  logic [itm_pkg::STAT_W-1:0] status_d;
  logic [itm_pkg::STAT_W-1:0] status_set;
  logic [itm_pkg::STAT_W-1:0] mask_q;
  logic [itm_pkg::DATA_W-1:0] rd_data_d;

  // pins cross into the clock domain before anything looks at them
  itm_sync #(
    .WIDTH(itm_pkg::NUM_TERM)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(term_in),
    .sync_out(term_sync)
  );

  // address fields; the same decode serves writes and reads
  assign wr_grp = bus_req.addr[itm_pkg::ADDR_W-1:itm_pkg::IDX_W];
  assign wr_idx = bus_req.addr[itm_pkg::IDX_W-1:0];
  assign cfg_idx_ok = wr_idx < itm_pkg::IDX_W'(itm_pkg::NUM_TERM);

  // whole-address strobes for the event registers
  assign status_wr = bus_req.wr && bus_req.addr == itm_pkg::ADDR_STATUS;
  assign mask_wr = bus_req.wr && bus_req.addr == itm_pkg::ADDR_MASK;

  // per-terminal configuration, polarity and option one-hot
  genvar gi;
  generate
    for (gi = 0; gi < itm_pkg::NUM_TERM; gi++)
    begin : g_term
      logic invert;
      logic func_wr;
      logic act_wr;

      // write hits for this terminal's two registers
      assign func_wr = bus_req.wr && wr_grp == itm_pkg::GRP_FUNC
        && wr_idx == itm_pkg::IDX_W'(gi);
      assign act_wr = bus_req.wr && wr_grp == itm_pkg::GRP_ACT
        && wr_idx == itm_pkg::IDX_W'(gi);

      // function select register, any option accepted
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          func_q[gi] <= itm_pkg::FUNC_RST[gi*itm_pkg::FUNC_W +: itm_pkg::FUNC_W];
        end
        else if (func_wr)
        begin
          func_q[gi] <= bus_req.wdata[itm_pkg::FUNC_W-1:0];
        end
      end

      // active-state register; a reset-option terminal refuses inversion
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          act_q[gi] <= itm_pkg::ACT_RST[gi];
        end
        else if (act_wr)
        begin
          if (func_q[gi] == itm_pkg::OPT_RESET)
          begin
            act_q[gi] <= itm_pkg::ACT_NO;
          end
          else
          begin
            act_q[gi] <= bus_req.wdata[0];
          end
        end
      end

      // masked here too, so a later switch to the reset option cannot invert
      assign invert = (act_q[gi] == itm_pkg::ACT_NC) && (func_q[gi] != itm_pkg::OPT_RESET);
      assign term_level[gi] = term_sync[gi] ^ invert;
      assign term_hot[gi] = term_level[gi] ? (itm_pkg::NUM_OPT'(1) << func_q[gi]) : '0;
    end
  endgenerate

  // shared options combine as a logical or
  always_comb
  begin
    opt_act = '0;
    for (int i = 0; i < itm_pkg::NUM_TERM; i++)
    begin
      opt_act = opt_act | term_hot[i];
    end
  end

  // run commands are held off while tripped or under reset
  assign reset_active = opt_act[itm_pkg::OPT_RESET];
  assign run_ok = !trip_latched_q && !reset_active;

  // rising edge of the merged trip line, once per transition
  assign ext_rise = opt_act[itm_pkg::OPT_EXT] && !ext_prev_q;

  // decode of the option levels into drive commands
  always_comb
  begin
    cmd_d = '0;
    // run requests are gated by trip and reset
    cmd_d.forward_run = opt_act[itm_pkg::OPT_FWD] && run_ok;
    cmd_d.reverse_run = opt_act[itm_pkg::OPT_REV] && run_ok;
    cmd_d.speed_sel = {opt_act[itm_pkg::OPT_SPD3], opt_act[itm_pkg::OPT_SPD2],
                       opt_act[itm_pkg::OPT_SPD1], opt_act[itm_pkg::OPT_SPD0]};
    cmd_d.jog_run = opt_act[itm_pkg::OPT_JOG] && run_ok;
    // the remaining selects pass through; they never start the motor
    cmd_d.dc_brake_request = opt_act[itm_pkg::OPT_DCB];
    cmd_d.motor_set2 = opt_act[itm_pkg::OPT_SET2];
    cmd_d.second_ramp_select = opt_act[itm_pkg::OPT_RAMP2];
    cmd_d.coast_stop = opt_act[itm_pkg::OPT_COAST];
    // coasting, reset and trip all cut the output
    cmd_d.out_off = opt_act[itm_pkg::OPT_COAST] || reset_active || trip_latched_q;
  end

  // command register, so outputs come straight from flops
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cmd_q <= '0;
    end
    else
    begin
      cmd_q <= cmd_d;
    end
  end

  // edge history; starts high so a line already active at reset does not trip
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ext_prev_q <= 1'b1;
    end
    else
    begin
      ext_prev_q <= opt_act[itm_pkg::OPT_EXT];
    end
  end

  // trip latch and code; a new edge wins over a same-cycle clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      trip_latched_q <= 1'b0;
      external_trip_code_q <= itm_pkg::TRIP_CODE_NONE;
    end
    else if (ext_rise)
    begin
      trip_latched_q <= 1'b1;
      external_trip_code_q <= itm_pkg::TRIP_CODE_EXT;
    end
    else if (reset_active)
    begin
      trip_latched_q <= 1'b0;
      external_trip_code_q <= itm_pkg::TRIP_CODE_NONE;
    end
  end

  // trip history survives the reset option, cleared only by sys_rst
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      trip_cnt_q <= '0;
    end
    else if (ext_rise && trip_cnt_q != itm_pkg::TRIP_CNT_MAX)
    begin
      trip_cnt_q <= trip_cnt_q + 8'h01;
    end
  end

  // sticky events: set beats a write-one clear
  always_comb
  begin
    status_set = '0;
    status_set[itm_pkg::STAT_TRIP] = ext_rise;
    status_set[itm_pkg::STAT_CLEAR] = reset_active && trip_latched_q;
    status_d = status_q;
    if (status_wr)
    begin
      status_d = status_d & ~bus_req.wdata[itm_pkg::STAT_W-1:0];
    end
    // set applied last so an event is never lost
    status_d = status_d | status_set;
  end

  // sticky status register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      status_q <= itm_pkg::STAT_RST;
    end
    else
    begin
      status_q <= status_d;
    end
  end

  // interrupt mask, written whole
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mask_q <= itm_pkg::STAT_RST;
    end
    else if (mask_wr)
    begin
      mask_q <= bus_req.wdata[itm_pkg::STAT_W-1:0];
    end
  end

  // interrupt level from the next status, so it rises with the event flop
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(status_d & mask_q);
    end
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    rd_data_d = '0;
    // configuration rows first, then the single registers
    if (wr_grp == itm_pkg::GRP_FUNC && cfg_idx_ok)
    begin
      rd_data_d = itm_pkg::DATA_W'(func_q[wr_idx]);
    end
    else if (wr_grp == itm_pkg::GRP_ACT && cfg_idx_ok)
    begin
      rd_data_d = itm_pkg::DATA_W'(act_q[wr_idx]);
    end
    else
    begin
      unique case (bus_req.addr)
        itm_pkg::ADDR_STATUS: rd_data_d = itm_pkg::DATA_W'(status_q);
        itm_pkg::ADDR_MASK: rd_data_d = itm_pkg::DATA_W'(mask_q);
        itm_pkg::ADDR_CMD: rd_data_d = cmd_q[itm_pkg::DATA_W-1:0];
        itm_pkg::ADDR_TRIP: rd_data_d = external_trip_code_q;
        itm_pkg::ADDR_TRIP_CNT: rd_data_d = trip_cnt_q;
        itm_pkg::ADDR_LEVEL: rd_data_d = itm_pkg::DATA_W'(term_level);
        default: rd_data_d = '0;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rd_data_q <= '0;
    end
    else if (bus_req.rd)
    begin
      rd_data_q <= rd_data_d;
    end
    else
    begin
      rd_data_q <= '0;
    end
  end

endmodule : itm_input_mapper

// ### rtl/itm_pkg.sv
package itm_pkg;

  // terminal count and option code width
  localparam int NUM_TERM = 6;
  localparam int FUNC_W = 5;
  localparam int NUM_OPT = 32;
  localparam int SPEED_W = 4;

  // register port geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int IDX_W = 3;
  localparam int GRP_W = 2;

  // function option codes
  localparam logic [FUNC_W-1:0] OPT_FWD = 5'h00;
  localparam logic [FUNC_W-1:0] OPT_REV = 5'h01;
  localparam logic [FUNC_W-1:0] OPT_SPD0 = 5'h02;
  localparam logic [FUNC_W-1:0] OPT_SPD1 = 5'h03;
  localparam logic [FUNC_W-1:0] OPT_SPD2 = 5'h04;
  localparam logic [FUNC_W-1:0] OPT_SPD3 = 5'h05;
  localparam logic [FUNC_W-1:0] OPT_JOG = 5'h06;
  localparam logic [FUNC_W-1:0] OPT_DCB = 5'h07;
  localparam logic [FUNC_W-1:0] OPT_SET2 = 5'h08;
  localparam logic [FUNC_W-1:0] OPT_RAMP2 = 5'h09;
  localparam logic [FUNC_W-1:0] OPT_COAST = 5'h0B;
  localparam logic [FUNC_W-1:0] OPT_EXT = 5'h0C;
  localparam logic [FUNC_W-1:0] OPT_RESET = 5'h12;

  // active-state codes
  localparam logic ACT_NO = 1'b0;
  localparam logic ACT_NC = 1'b1;

  // register map: group in addr[4:3], terminal index in addr[2:0]
  localparam logic [GRP_W-1:0] GRP_FUNC = 2'h0;
  localparam logic [GRP_W-1:0] GRP_ACT = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 5'h11;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 5'h12;
  localparam logic [ADDR_W-1:0] ADDR_TRIP = 5'h13;
  localparam logic [ADDR_W-1:0] ADDR_TRIP_CNT = 5'h14;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL = 5'h15;

  // reset values, terminal 0 in the low field
  localparam logic [FUNC_W*NUM_TERM-1:0] FUNC_RST = {5'h09, 5'h12, 5'h03, 5'h02, 5'h01, 5'h00};
  localparam logic [NUM_TERM-1:0] ACT_RST = 6'h00;

  // trip codes
  localparam logic [DATA_W-1:0] TRIP_CODE_NONE = 8'h00;
  localparam logic [DATA_W-1:0] TRIP_CODE_EXT = 8'h0C;
  localparam logic [DATA_W-1:0] TRIP_CNT_MAX = 8'hFF;

  // status and mask layout
  localparam int STAT_W = 2;
  localparam int STAT_TRIP = 0;
  localparam int STAT_CLEAR = 1;
  localparam logic [STAT_W-1:0] STAT_RST = 2'h0;

  // synchroniser depth
  localparam int SYNC_STAGES = 2;

  // drive commands toward the motor control
  typedef struct packed {
    logic out_off;
    logic coast_stop;
    logic second_ramp_select;
    logic motor_set2;
    logic dc_brake_request;
    logic jog_run;
    logic [SPEED_W-1:0] speed_sel;
    logic reverse_run;
    logic forward_run;
  } itm_cmd_s;

  localparam int CMD_W = $bits(itm_cmd_s);

  // software register request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } itm_bus_req_s;

endpackage : itm_pkg

// ### rtl/itm_sync.sv
`timescale 1ns/10ps

module itm_sync #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pins and synchronised copy
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  // two flops; only the second flop reads the first
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_q <= '0;
      stable_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;

endmodule : itm_sync

// ### testbench/itm_input_mapper_props.sv
`timescale 1ns/10ps

module itm_input_mapper_props (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // watched ports
  input wire logic [itm_pkg::NUM_TERM-1:0] term_in,
  input wire itm_pkg::itm_bus_req_s bus_req,
  input wire logic [itm_pkg::DATA_W-1:0] rd_data_q,
  input wire itm_pkg::itm_cmd_s cmd_q,
  input wire logic trip_latched_q,
  input wire logic [itm_pkg::DATA_W-1:0] external_trip_code_q,
  input wire logic irq_q
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // read data only in the slot after a read strobe
  a_rd_idle_zero: assert property (!$past(bus_req.rd) |-> rd_data_q == '0)
    else $error("read data not zero outside read slot");
  // code shown exactly while a trip is latched
  a_trip_code_set: assert property (external_trip_code_q ==
    (trip_latched_q ? itm_pkg::TRIP_CODE_EXT : itm_pkg::TRIP_CODE_NONE))
    else $error("trip code does not follow trip latch");
  // output off one cycle after a latched trip
  a_trip_out_off: assert property ($past(trip_latched_q) && !$past(sys_rst) |->
    cmd_q.out_off)
    else $error("output not off after trip");
  a_trip_no_run: assert property (trip_latched_q && $past(trip_latched_q)
    |-> !cmd_q.forward_run && !cmd_q.reverse_run && !cmd_q.jog_run)
    else $error("run command while tripped");
  // reset clears the commands, the trip latch and the interrupt
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=>
    cmd_q == '0 && !trip_latched_q && !irq_q)
    else $error("outputs not cleared by reset");
  // the interrupt moves only after a trip event or change, or a register write
  a_irq_rise_cause: assert property ($rose(irq_q) |-> $changed(trip_latched_q) ||
    trip_latched_q || $past(trip_latched_q) != $past(trip_latched_q, 2) ||
    $past(bus_req.wr) || $past(bus_req.wr, 2))
    else $error("interrupt rose without cause");
  a_irq_fall_write: assert property ($fell(irq_q) && !$past(sys_rst) |->
    $past(bus_req.wr) || $past(bus_req.wr, 2))
    else $error("interrupt fell without a write");
  // clearing comes from the reset option, which keeps output off
  a_trip_clear_off: assert property ($fell(trip_latched_q) && !$past(sys_rst) |->
    cmd_q.out_off)
    else $error("trip cleared with output on");

  c_trip_set: cover property ($rose(trip_latched_q));
  c_trip_clear: cover property ($fell(trip_latched_q));
  c_irq_up: cover property ($rose(irq_q));
endmodule : itm_input_mapper_props

bind itm_input_mapper itm_input_mapper_props u_props (.clk(clk), .sys_rst(sys_rst),
  .term_in(term_in), .bus_req(bus_req), .rd_data_q(rd_data_q), .cmd_q(cmd_q),
  .trip_latched_q(trip_latched_q), .external_trip_code_q(external_trip_code_q),
  .irq_q(irq_q));

// ### testbench/itm_input_mapper_tb.sv
`timescale 1ns/10ps

module itm_input_mapper_tb;
  logic clk;
  logic sys_rst;
  logic [5:0] want;
  logic [5:0] term_in;
  itm_pkg::itm_bus_req_s bus_req;
  logic [7:0] rd_data_q;
  itm_pkg::itm_cmd_s cmd_q;
  logic trip_latched_q;
  logic [7:0] external_trip_code_q;
  logic irq_q;
  int err_total;
  int total_checks;
  int seed;
  int k;
  logic [4:0] fn [6];
  logic [5:0] act;
  logic trip;

  itm_input_mapper DUT (.clk(clk), .sys_rst(sys_rst), .term_in(term_in),
    .bus_req(bus_req), .rd_data_q(rd_data_q), .cmd_q(cmd_q),
    .trip_latched_q(trip_latched_q), .external_trip_code_q(external_trip_code_q),
    .irq_q(irq_q));
  itm_switch_model u_sw (.clk(clk), .want(want), .term_in(term_in));

  // 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr_reg

  // data is looked at only in the single cycle it stands
  task automatic rd_reg(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 check("rd_data_q", {8'h00, rd_data_q}, {8'h00, e});
  endtask : rd_reg

  // the reset option never keeps an inverted sense
  task automatic cfg(input int i, input logic [4:0] f, input logic a);
    wr_reg(5'(i), {3'h0, f});
    wr_reg(5'(8 + i), {7'h00, a});
    fn[i] = f;
    act[i] = a & (f != itm_pkg::OPT_RESET);
  endtask : cfg

  // active options after polarity, shared options ORed
  function automatic logic [18:0] onv(input logic [5:0] p);
    onv = '0;
    for (int i = 0; i < 6; i++)
      onv[fn[i]] |= p[i] ^ act[i];
  endfunction : onv

  function automatic logic [15:0] exp_cmd(input logic [18:0] o);
    logic stop;
    stop = trip | o[18];
    exp_cmd = {5'h00, stop | o[11], o[11], o[9], o[8], o[7], o[6] & ~stop, o[5:2],
      o[1] & ~stop, o[0] & ~stop};
  endfunction : exp_cmd

  // trip edge wins over a reset option seen in the same cycle
  task automatic set_pins(input logic [5:0] p);
    logic [5:0] was;
    logic [18:0] o;
    was = want ^ act;
    o = onv(p);
    @(posedge clk);
    want <= p;
    if (o[18])
      trip = 1'b0;
    for (int i = 0; i < 6; i++)
      if (fn[i] == itm_pkg::OPT_EXT && (p[i] ^ act[i]) && !was[i])
        trip = 1'b1;
    repeat (5) @(posedge clk);
    #1 check("cmd_q", {5'h00, cmd_q}, exp_cmd(o));
    check("trip_latched_q", {15'h0, trip_latched_q}, {15'h0, trip});
    check("trip code", {8'h0, external_trip_code_q},
      {8'h00, trip ? itm_pkg::TRIP_CODE_EXT : itm_pkg::TRIP_CODE_NONE});
  endtask : set_pins

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // hang guard, far beyond the roughly 1100 cycles needed
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end

  initial
  begin
    seed = 9;
    sys_rst = 1'b1;
    want = '0;
    bus_req = '0;
    err_total = 0;
    total_checks = 0;
    trip = 1'b0;
    act = '0;
    for (int i = 0; i < 6; i++)
      fn[i] = itm_pkg::FUNC_RST[5*i+:5];
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      rd_reg(5'(i), {3'h0, fn[i]});
      rd_reg(5'(8 + i), 8'h00);
    end
    rd_reg(5'h1F, 8'h00);
    $display("test reset values done");
    // random mapping; first two passes all pins low, then all high
    for (int n = 0; n < 30; n++)
    begin
      for (int i = 0; i < 6; i++)
      begin
        k = $unsigned($random(seed)) % 11;
        cfg(i, (k == 10) ? itm_pkg::OPT_COAST : 5'(k), $random(seed));
      end
      set_pins(n < 2 ? {6{n[0]}} : 6'($random(seed)));
      rd_reg(itm_pkg::ADDR_LEVEL, {2'h0, want ^ act});
    end
    $display("test random mapping done");
    // plain sense and quiet pins first, so remapping cannot fake a trip edge
    for (int i = 0; i < 6; i++)
      cfg(i, fn[i], 1'b0);
    set_pins(6'h00);
    cfg(4, itm_pkg::OPT_RESET, 1'b1);
    rd_reg(5'h0C, 8'h00);
    cfg(0, itm_pkg::OPT_EXT, 1'b0);
    cfg(1, itm_pkg::OPT_RESET, 1'b0);
    cfg(2, itm_pkg::OPT_FWD, 1'b0);
    set_pins(6'h00);
    wr_reg(itm_pkg::ADDR_STATUS, 8'h03);
    wr_reg(itm_pkg::ADDR_MASK, 8'h01);
    set_pins(6'h04);
    rd_reg(itm_pkg::ADDR_CMD, 8'h01);
    set_pins(6'h05);
    check("irq_q", {15'h0, irq_q}, 16'h1);
    set_pins(6'h04);
    rd_reg(itm_pkg::ADDR_TRIP_CNT, 8'h01);
    set_pins(6'h06);
    rd_reg(itm_pkg::ADDR_STATUS, 8'h03);
    wr_reg(itm_pkg::ADDR_STATUS, 8'h03);
    repeat (2) @(posedge clk);
    #1 check("irq_q", {15'h0, irq_q}, 16'h0);
    wr_reg(itm_pkg::ADDR_MASK, 8'h00);
    set_pins(6'h04);
    set_pins(6'h05);
    check("irq_q", {15'h0, irq_q}, 16'h0);
    rd_reg(itm_pkg::ADDR_STATUS, 8'h01);
    rd_reg(itm_pkg::ADDR_TRIP_CNT, 8'h02);
    rd_reg(itm_pkg::ADDR_TRIP, itm_pkg::TRIP_CODE_EXT);
    rd_reg(itm_pkg::ADDR_MASK, 8'h00);
    $display("test trip sequence done");
    end_of_test();
  end
endmodule : itm_input_mapper_tb

// ### testbench/itm_switch_model.sv
`timescale 1ns/10ps

module itm_switch_model (
  // clock
  input wire logic clk,
  // requested and driven levels
  input wire logic [itm_pkg::NUM_TERM-1:0] want,
  output logic [itm_pkg::NUM_TERM-1:0] term_in
);
  // contacts open at power up; levels move one edge late, like a controller
  initial term_in = '0;
  always @(posedge clk)
    term_in <= want;
endmodule : itm_switch_model
